// file: hdl/pmc_pkg.sv
// Constants for the power-management control register and tick counter
package pmc_pkg;
    // Control register field positions
    localparam int unsigned CTL_ROUTE_BIT   = 0;
    localparam int unsigned CTL_BMWAKE_BIT  = 1;
    localparam int unsigned CTL_GLREL_BIT   = 2;
    localparam int unsigned CTL_STYPE_LSB   = 10;
    localparam int unsigned CTL_STYPE_W     = 3;
    localparam int unsigned CTL_STRIG_BIT   = 13;
    localparam int unsigned CTL_WIDTH       = 16;
    // Readable bits; all others read zero, writes ignored except bits 2 and 13
    localparam logic [15:0] CTL_IMPL_MASK   = 16'h1C03;
    localparam logic [15:0] CTL_RESET       = 16'h0000;
    localparam logic [31:0] TMR_RESET       = 32'h00000000;
    localparam int unsigned TMR_NARROW_MSB  = 23;
    localparam int unsigned TMR_WIDE_MSB    = 31;
    localparam logic [31:0] TMR_NARROW_MASK = 32'h00FFFFFF;
    localparam logic [31:0] TMR_WIDE_MASK   = 32'hFFFFFFFF;
    // Tick rate generation: 3.579545 MHz from the 25 MHz system clock
    localparam longint unsigned SYS_CLK_HZ  = 64'd25000000;
    localparam longint unsigned TICK_HZ     = 64'd3579545;
    localparam logic [24:0] TICK_STEP       = 25'(TICK_HZ);
    localparam logic [24:0] TICK_MODULUS    = 25'(SYS_CLK_HZ);
    localparam logic [3:0]  BE_FULL_WORD    = 4'hF;
endpackage

// file: hdl/pmc_top.sv
// Power-management control register and free-running tick counter
//
// Behaviour
// - Unimplemented control bits read zero, ignore writes
// - Control bits keep their defined positions
// - Control block takes byte and word accesses
// - Bit 0 routes events: OS or firmware
// - Only hardware changes the route select
// - Bit 1 lets bus master wake idle
// - Writing one to bit 2 raises firmware interrupt
// - Release event has firmware status and enable
// - Bits 14 and 15 read zero
// - Bits 3 to 9 carry no function
// - Bits 10 to 12 select sleep type
// - Sleep trigger is write-only, reads zero
// - Sleep trigger write starts selected sleep
// - Timer is read-only full 32-bit word
// - Low 24 bits count at 3.579545 MHz
// - Timer start value free; kept across wake
// - Timer holds while source clock stopped
// - Strap selects 24 or 32-bit width
// - Upper byte counts or reads zero
// - Top implemented bit toggle sets carry status
// - Enabled carry status raises OS event when bit 0 is set, firmware interrupt when clear
`timescale 1ns/1ps
`default_nettype none
module pmc_top
    import pmc_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RESET,
    // Host register access
    input  wire logic        CTL_SEL,
    input  wire logic        TMR_SEL,
    input  wire logic        IO_WR,
    input  wire logic        IO_RD,
    input  wire logic [3:0]  IO_BE,
    input  wire logic [31:0] IO_WDATA,
    output logic      [31:0] IO_RDATA,
    output logic             IO_RVALID,
    // Hardware route control
    input  wire logic        ROUTE_SET,
    input  wire logic        ROUTE_CLEAR,
    // Enable bits held elsewhere; clears for the status bits held here
    input  wire logic        TIMER_CARRY_IRQ_ENABLE,
    input  wire logic        TIMER_CARRY_CLEAR,
    input  wire logic        FIRMWARE_EVENT_ENABLE,
    input  wire logic        FIRMWARE_EVENT_CLEAR,
    // Pins from the platform
    input  wire logic        BUS_MASTER_REQ,
    input  wire logic        SYS_WORKING,
    input  wire logic        TIMER_SRC_RUN,
    input  wire logic        TIMER_WIDE_STRAP,
    // Outputs
    output logic             OS_EVENT_IRQ,
    output logic             FIRMWARE_MGMT_IRQ,
    output logic             DEEP_IDLE_WAKE,
    output logic             SLEEP_START,
    output logic      [2:0]  SLEEP_TYPE,
    output logic             TIMER_CARRY_STATUS,
    output logic             FIRMWARE_EVENT_STATUS,
    output logic             TIMER_WIDTH_SELECT
);
    // Two-flop synchronisers for pins: bm, working, run, strap
    logic [3:0]  sync1;
    logic [3:0]  sync2;
    logic [3:0]  pins;
    assign pins = {TIMER_WIDE_STRAP, TIMER_SRC_RUN, SYS_WORKING, BUS_MASTER_REQ};

    logic        route_select;
    logic        bm_wake_enable;
    logic [2:0]  sleep_type;
    logic [24:0] tick_acc;
    logic [31:0] timer_count;
    logic        carry_status;
    logic        fw_status;
    logic        width_select;
    logic        strap_taken;
    logic [31:0] rdata;
    logic        rvalid;
    logic        os_irq;
    logic        fw_irq;
    logic        wake;
    logic        sleep_go;

    logic        next_route_select;
    logic        next_bm_wake_enable;
    logic [2:0]  next_sleep_type;
    logic [24:0] next_tick_acc;
    logic [31:0] next_timer_count;
    logic        next_carry_status;
    logic        next_fw_status;
    logic        next_width_select;
    logic        next_strap_taken;
    logic [31:0] next_rdata;
    logic        next_rvalid;
    logic        next_os_irq;
    logic        next_fw_irq;
    logic        next_wake;
    logic        next_sleep_go;

    logic [15:0] ctl_view;
    logic        ctl_wr_lo;
    logic        ctl_wr_hi;
    logic        tick;
    logic [25:0] acc_sum;
    logic        msb_now;
    logic        msb_next;

    always_comb begin
        // Readback: implemented bits only; write-only bits read zero
        ctl_view = 16'h0000;
        ctl_view[CTL_ROUTE_BIT] = route_select;
        ctl_view[CTL_BMWAKE_BIT] = bm_wake_enable;
        ctl_view[CTL_STYPE_LSB +: CTL_STYPE_W] = sleep_type;
        ctl_view = ctl_view & CTL_IMPL_MASK;

        ctl_wr_lo = CTL_SEL && IO_WR && IO_BE[0];
        ctl_wr_hi = CTL_SEL && IO_WR && IO_BE[1];
    end

    always_comb begin
        next_strap_taken = 1'b1;
        next_width_select = strap_taken ? width_select : sync2[3];
    end

    always_comb begin
        // Route select moves only on hardware requests
        next_route_select = route_select;
        if (ROUTE_SET) begin
            next_route_select = 1'b1;
        end else if (ROUTE_CLEAR) begin
            next_route_select = 1'b0;
        end
    end

    always_comb begin
        next_bm_wake_enable = bm_wake_enable;
        if (ctl_wr_lo) begin
            next_bm_wake_enable = IO_WDATA[CTL_BMWAKE_BIT];
        end
        next_wake = bm_wake_enable && sync2[0];
    end

    always_comb begin
        next_sleep_type = sleep_type;
        next_sleep_go = 1'b0;
        if (ctl_wr_hi) begin
            next_sleep_type = IO_WDATA[CTL_STYPE_LSB +: CTL_STYPE_W];
            next_sleep_go = IO_WDATA[CTL_STRIG_BIT];
        end
    end

    always_comb begin
        // Release write sets firmware status; set wins over clear
        next_fw_status = fw_status;
        if (FIRMWARE_EVENT_CLEAR) begin
            next_fw_status = 1'b0;
        end
        if (ctl_wr_lo && IO_WDATA[CTL_GLREL_BIT]) begin
            next_fw_status = 1'b1;
        end
    end

    always_comb begin
        // Fractional divider gives the 3.579545 MHz tick
        acc_sum = {1'b0, tick_acc} + {1'b0, TICK_STEP};
        tick = (acc_sum >= {1'b0, TICK_MODULUS});
        if (tick) begin
            next_tick_acc = 25'(acc_sum - {1'b0, TICK_MODULUS});
        end else begin
            next_tick_acc = acc_sum[24:0];
        end
    end

    always_comb begin
        // Counts only in working state with its source clock running
        next_timer_count = timer_count;
        if (tick && sync2[1] && sync2[2]) begin
            next_timer_count = timer_count + 32'h00000001;
        end
        msb_now = width_select ? timer_count[TMR_WIDE_MSB] : timer_count[TMR_NARROW_MSB];
        msb_next = width_select ? next_timer_count[TMR_WIDE_MSB]
                                : next_timer_count[TMR_NARROW_MSB];

        next_carry_status = carry_status;
        if (TIMER_CARRY_CLEAR) begin
            next_carry_status = 1'b0;
        end
        if (msb_now != msb_next) begin
            next_carry_status = 1'b1;
        end
    end

    always_comb begin
        // Event routing of the carry event and release event
        next_os_irq = route_select && carry_status && TIMER_CARRY_IRQ_ENABLE;
        next_fw_irq = (fw_status && FIRMWARE_EVENT_ENABLE)
                    || (!route_select && carry_status && TIMER_CARRY_IRQ_ENABLE);
    end

    always_comb begin
        // Read path
        next_rvalid = IO_RD && (CTL_SEL || TMR_SEL);
        next_rdata = 32'h00000000;
        if (IO_RD && CTL_SEL) begin
            if (IO_BE[0]) begin
                next_rdata[7:0] = ctl_view[7:0];
            end
            if (IO_BE[1]) begin
                next_rdata[15:8] = ctl_view[15:8];
            end
        end else if (IO_RD && TMR_SEL && IO_BE == BE_FULL_WORD) begin
            next_rdata = timer_count & (width_select ? TMR_WIDE_MASK
                                                     : TMR_NARROW_MASK);
        end
    end

    always_ff @(posedge CLK) begin
        sync1 <= pins;
        sync2 <= sync1;
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            width_select <= 1'b0;
            strap_taken  <= 1'b0;
        end else begin
            width_select <= next_width_select;
            strap_taken  <= next_strap_taken;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            route_select <= CTL_RESET[CTL_ROUTE_BIT];
        end else begin
            route_select <= next_route_select;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            bm_wake_enable <= CTL_RESET[CTL_BMWAKE_BIT];
            wake           <= 1'b0;
        end else begin
            bm_wake_enable <= next_bm_wake_enable;
            wake           <= next_wake;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            sleep_type <= CTL_RESET[CTL_STYPE_LSB +: CTL_STYPE_W];
            sleep_go   <= 1'b0;
        end else begin
            sleep_type <= next_sleep_type;
            sleep_go   <= next_sleep_go;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            fw_status <= 1'b0;
        end else begin
            fw_status <= next_fw_status;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            tick_acc <= 25'h0000000;
        end else begin
            tick_acc <= next_tick_acc;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            timer_count  <= TMR_RESET;
            carry_status <= 1'b0;
        end else begin
            timer_count  <= next_timer_count;
            carry_status <= next_carry_status;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            os_irq <= 1'b0;
            fw_irq <= 1'b0;
        end else begin
            os_irq <= next_os_irq;
            fw_irq <= next_fw_irq;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            rdata  <= 32'h00000000;
            rvalid <= 1'b0;
        end else begin
            rdata  <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    assign IO_RDATA              = rdata;
    assign IO_RVALID             = rvalid;
    assign OS_EVENT_IRQ          = os_irq;
    assign FIRMWARE_MGMT_IRQ     = fw_irq;
    assign DEEP_IDLE_WAKE        = wake;
    assign SLEEP_START           = sleep_go;
    assign SLEEP_TYPE            = sleep_type;
    assign TIMER_CARRY_STATUS    = carry_status;
    assign FIRMWARE_EVENT_STATUS = fw_status;
    assign TIMER_WIDTH_SELECT    = width_select;
endmodule
`default_nettype wire

// file: sim/pmc_assertions.sv
// Port checker for the power-management control and tick counter
`timescale 1ns/1ps
`default_nettype none
module pmc_checker (
    // Clock and reset
    input wire logic        CLK,
    input wire logic        RESET,
    // Host access
    input wire logic        CTL_SEL,
    input wire logic        TMR_SEL,
    input wire logic        IO_WR,
    input wire logic        IO_RD,
    input wire logic [3:0]  IO_BE,
    input wire logic [31:0] IO_WDATA,
    input wire logic [31:0] IO_RDATA,
    input wire logic        IO_RVALID,
    // Side pins
    input wire logic        FIRMWARE_EVENT_ENABLE,
    input wire logic        BUS_MASTER_REQ,
    input wire logic        FIRMWARE_MGMT_IRQ,
    input wire logic        DEEP_IDLE_WAKE,
    input wire logic        SLEEP_START,
    input wire logic [2:0]  SLEEP_TYPE,
    input wire logic        FIRMWARE_EVENT_STATUS,
    input wire logic        TIMER_CARRY_IRQ_ENABLE,
    input wire logic        TIMER_CARRY_STATUS,
    input wire logic        OS_EVENT_IRQ
);
    default clocking dc @(posedge CLK);
    endclocking
    default disable iff (RESET);
    chk_read_answer: assert property (IO_RD && (CTL_SEL || TMR_SEL) |=> IO_RVALID)
        else $error("read not answered");
    chk_ctl_zero_bits: assert property (IO_RVALID && $past(CTL_SEL) |->
        (IO_RDATA & 32'hFFFFE3FC) == 32'h0) else $error("control bits not zero");
    chk_timer_partial: assert property (IO_RD && TMR_SEL && IO_BE != 4'hF |=>
        IO_RDATA == 32'h0) else $error("partial timer read not zero");
    chk_sleep_type: assert property (IO_WR && CTL_SEL && IO_BE[1] && IO_WDATA[13] |=>
        SLEEP_START && SLEEP_TYPE == $past(IO_WDATA[12:10])) else $error("sleep start wrong");
    chk_sleep_cause: assert property (SLEEP_START |->
        $past(IO_WR && CTL_SEL && IO_BE[1] && IO_WDATA[13])) else $error("spurious sleep");
    chk_release_status: assert property (IO_WR && CTL_SEL && IO_BE[0] && IO_WDATA[2] |=>
        FIRMWARE_EVENT_STATUS) else $error("release not captured");
    chk_fw_irq_gate: assert property (FIRMWARE_EVENT_STATUS && FIRMWARE_EVENT_ENABLE |=>
        FIRMWARE_MGMT_IRQ) else $error("firmware interrupt missing");
    chk_bm_wake: assert property (DEEP_IDLE_WAKE |-> $past(BUS_MASTER_REQ, 3))
        else $error("wake without request");
    chk_os_irq_cause: assert property (OS_EVENT_IRQ |->
        $past(TIMER_CARRY_STATUS && TIMER_CARRY_IRQ_ENABLE)) else $error("event without carry");
endmodule
`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the power-management control and tick counter
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        CLK, RESET, CTL_SEL, TMR_SEL, IO_WR, IO_RD, ROUTE_SET, ROUTE_CLEAR;
    logic        TC_EN, TC_CLR, FW_EN, FW_CLR, BM_REQ, WORK, SRC_RUN, WIDE, RVALID;
    logic        OS_IRQ, FW_IRQ, WAKE, SLP_GO, TC_STS, FW_STS, WSEL;
    logic [3:0]  IO_BE;
    logic [31:0] IO_WDATA, IO_RDATA, rd, t0;
    logic [2:0]  SLP_TYPE;
    int          err_count = 0, check_count = 0, cycles = 0;
    pmc_top pmc_top_i (.CLK(CLK), .RESET(RESET), .CTL_SEL(CTL_SEL), .TMR_SEL(TMR_SEL),
        .IO_WR(IO_WR), .IO_RD(IO_RD), .IO_BE(IO_BE), .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA),
        .IO_RVALID(RVALID), .ROUTE_SET(ROUTE_SET), .ROUTE_CLEAR(ROUTE_CLEAR),
        .TIMER_CARRY_IRQ_ENABLE(TC_EN), .TIMER_CARRY_CLEAR(TC_CLR),
        .FIRMWARE_EVENT_ENABLE(FW_EN), .FIRMWARE_EVENT_CLEAR(FW_CLR),
        .BUS_MASTER_REQ(BM_REQ), .SYS_WORKING(WORK), .TIMER_SRC_RUN(SRC_RUN),
        .TIMER_WIDE_STRAP(WIDE), .OS_EVENT_IRQ(OS_IRQ), .FIRMWARE_MGMT_IRQ(FW_IRQ),
        .DEEP_IDLE_WAKE(WAKE), .SLEEP_START(SLP_GO), .SLEEP_TYPE(SLP_TYPE),
        .TIMER_CARRY_STATUS(TC_STS), .FIRMWARE_EVENT_STATUS(FW_STS),
        .TIMER_WIDTH_SELECT(WSEL));
    initial begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end
    always @(posedge CLK) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        if (err_count == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Idle edge first, then one access; returns on the falling edge after it
    task automatic acc(input logic w, input logic c, input logic [3:0] be, input logic [31:0] d);
        @(negedge CLK);
        {IO_WR, IO_RD, CTL_SEL, TMR_SEL, IO_BE, IO_WDATA} = {w, !w, c, !c, be, d};
        @(negedge CLK);
        {IO_WR, IO_RD, CTL_SEL, TMR_SEL} = 4'h0;
        rd = IO_RDATA;
        if (!w) check(RVALID, 1);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge CLK);
        s = 1'b0;
    endtask
    task automatic do_reset();
        RESET = 1'b1;
        repeat (10) @(negedge CLK);
        RESET = 1'b0;
    endtask
    task automatic t_ctl_fields();
        acc(0, 1, 4'h3, 0);
        check(rd, 0);
        acc(1, 1, 4'hF, 32'hFFFFFFFE);
        check(SLP_GO, 1);
        acc(0, 1, 4'hF, 0);
        check(rd, 32'h00001C02);
        check(FW_IRQ, 0);
        pulse(ROUTE_SET);
        acc(1, 1, 4'h1, 0);
        acc(0, 1, 4'h3, 0);
        check(rd, 32'h00001C01);
        pulse(ROUTE_CLEAR);
        acc(0, 1, 4'h3, 0);
        check(rd, 32'h00001C00);
    endtask
    task automatic t_sleep();
        for (int i = 0; i < 8; i++) begin
            acc(1, 1, 4'h2, {18'h0, 1'b1, i[2:0], 10'h0});
            check({SLP_GO, SLP_TYPE}, {1'b1, i[2:0]});
        end
        acc(1, 1, 4'h2, 32'h00000800);
        check({SLP_GO, SLP_TYPE}, 4'h2);
    endtask
    task automatic t_release();
        pulse(FW_CLR);
        FW_EN = 1'b1;
        acc(1, 1, 4'h1, 32'h4);
        check(FW_STS, 1);
        @(negedge CLK);
        check(FW_IRQ, 1);
        pulse(FW_CLR);
        acc(1, 1, 4'h1, 0);
        check({FW_STS, FW_IRQ}, 0);
        FW_EN = 1'b0;
        acc(1, 1, 4'h1, 32'h4);
        @(negedge CLK);
        check({FW_STS, FW_IRQ}, 2'b10);
        pulse(FW_CLR);
    endtask
    task automatic t_wake();
        acc(1, 1, 4'h1, 32'h2);
        BM_REQ = 1'b1;
        repeat (3) @(negedge CLK);
        check(WAKE, 1);
        acc(1, 1, 4'h1, 0);
        @(negedge CLK);
        check(WAKE, 0);
        BM_REQ = 1'b0;
    endtask
    task automatic t_timer();
        TC_EN = 1'b1;
        pulse(TC_CLR);
        acc(0, 0, 4'hF, 0);
        t0 = rd;
        repeat (199) @(negedge CLK);
        acc(0, 0, 4'hF, 0);
        check(rd - t0 == 28 || rd - t0 == 29, 1);
        check(rd[31:24], 0);
        check(WSEL, 0);
        acc(0, 0, 4'h3, 0);
        check(rd, 0);
        SRC_RUN = 1'b0;
        repeat (5) @(negedge CLK);
        acc(0, 0, 4'hF, 0);
        t0 = rd;
        repeat (50) @(negedge CLK);
        acc(0, 0, 4'hF, 0);
        check(rd, t0);
        SRC_RUN = 1'b1;
        WORK = 1'b0;
        repeat (5) @(negedge CLK);
        acc(0, 0, 4'hF, 0);
        t0 = rd;
        repeat (50) @(negedge CLK);
        acc(0, 0, 4'hF, 0);
        check(rd, t0);
        WORK = 1'b1;
        repeat (50) @(negedge CLK);
        acc(0, 0, 4'hF, 0);
        check(rd > t0, 1);
        check({OS_IRQ, TC_STS, FW_IRQ}, 0);
        WIDE = 1'b1;
        do_reset();
        @(negedge CLK);
        check(WSEL, 1);
        acc(0, 1, 4'h3, 0);
        check(rd, 0);
    endtask
    initial begin
        {CTL_SEL, TMR_SEL, IO_WR, IO_RD, ROUTE_SET, ROUTE_CLEAR, TC_EN, TC_CLR} = 8'h0;
        {FW_EN, FW_CLR, BM_REQ, WIDE, IO_BE, IO_WDATA} = '0;
        {WORK, SRC_RUN} = 2'b11;
        do_reset();
        t_ctl_fields();
        t_sleep();
        t_release();
        t_wake();
        t_timer();
        tally_and_finish();
    end
endmodule
bind pmc_top pmc_checker pmc_checker_i (.CLK(CLK), .RESET(RESET), .CTL_SEL(CTL_SEL),
    .TMR_SEL(TMR_SEL), .IO_WR(IO_WR), .IO_RD(IO_RD), .IO_BE(IO_BE), .IO_WDATA(IO_WDATA),
    .IO_RDATA(IO_RDATA), .IO_RVALID(IO_RVALID), .FIRMWARE_EVENT_ENABLE(FIRMWARE_EVENT_ENABLE),
    .BUS_MASTER_REQ(BUS_MASTER_REQ), .FIRMWARE_MGMT_IRQ(FIRMWARE_MGMT_IRQ),
    .DEEP_IDLE_WAKE(DEEP_IDLE_WAKE), .SLEEP_START(SLEEP_START), .SLEEP_TYPE(SLEEP_TYPE),
    .FIRMWARE_EVENT_STATUS(FIRMWARE_EVENT_STATUS),
    .TIMER_CARRY_IRQ_ENABLE(TIMER_CARRY_IRQ_ENABLE),
    .TIMER_CARRY_STATUS(TIMER_CARRY_STATUS), .OS_EVENT_IRQ(OS_EVENT_IRQ));
`default_nettype wire
